// ===== rtl/exp_bus_pkg.sv
// Constants and types shared by the expansion bus access sequencer.
package exp_bus_pkg;

	// ==========================================================
	// Phase settings
	// ==========================================================
	localparam int SETTING_W = 2;
	localparam int RECOV_W = 4;
	localparam logic [SETTING_W-1:0] ADDR_SETTING_MIN = 2'h2;
	localparam logic [SETTING_W-1:0] SETUP_SETTING_MIN = 2'h2;
	localparam logic [SETTING_W-1:0] STROBE_SETTING_MIN = 2'h1;
	localparam logic [RECOV_W-1:0] RECOV_BASE = 4'h1;
	localparam int CHIP_SELECTS = 8;

	// ==========================================================
	// Bus styles and sequencer states
	// ==========================================================
	typedef enum logic [1:0] {
		STYLE_RW_STROBE,
		STYLE_SEP_STROBE,
		STYLE_HOST_PORT
	} bus_style_e;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_RECOV
	} phase_e;

	// Counter reload for a phase: setting plus one clock in total.
	function automatic logic [RECOV_W-1:0] phase_len(input logic [RECOV_W-1:0] setting);
		phase_len = setting;
	endfunction

endpackage

// ===== rtl/exp_bus_seq.sv
// Expansion bus access sequencer for the 16-bit DSP host port and slow peripherals.
`timescale 1ns/1ps
module exp_bus_seq #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [2:0] req_cs,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	input wire exp_bus_pkg::bus_style_e bus_style,
	input wire logic sync_write,
	input wire logic [exp_bus_pkg::SETTING_W-1:0] address_phase_setting,
	input wire logic [exp_bus_pkg::SETTING_W-1:0] data_setup_phase_setting,
	input wire logic [exp_bus_pkg::SETTING_W-1:0] data_strobe_phase_setting,
	input wire logic [exp_bus_pkg::RECOV_W-1:0] recovery_phase_setting,
	input wire logic host_ready_hold,
	input wire logic wait_request_n,
	input wire logic [DATA_W-1:0] bus_data_in,
	output logic req_ready,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	output logic setting_error,
	output logic [7:0] chip_select_n,
	output logic [ADDR_W-1:0] bus_addr,
	output logic host_data_strobe_n,
	output logic [DATA_W-1:0] bus_data_out,
	output logic bus_data_oe
);

	// ==========================================================
	// Sequencer state
	// ==========================================================
	exp_bus_pkg::phase_e phase;
	exp_bus_pkg::phase_e next_phase;
	logic [exp_bus_pkg::RECOV_W-1:0] count;
	logic [exp_bus_pkg::RECOV_W-1:0] next_count;
	logic is_write;
	logic use_wait;
	logic count_done;
	logic hold_seen;
	logic wait_seen;
	logic settings_bad;

	assign count_done = (count == '0);

	// Host port settings below minimum would leave no room to see the hold line.
	assign settings_bad = (bus_style == exp_bus_pkg::STYLE_HOST_PORT) &&
		((address_phase_setting < exp_bus_pkg::ADDR_SETTING_MIN) ||
		(data_setup_phase_setting < exp_bus_pkg::SETUP_SETTING_MIN) ||
		(data_strobe_phase_setting < exp_bus_pkg::STROBE_SETTING_MIN));

	// Next phase and counter; the hold line is sampled in address, setup and strobe phases.
	always_comb
	begin
		next_phase = phase;
		next_count = count;
		if (count != '0)
		begin
			next_count = count - 1'b1;
		end
		unique case (phase)
			exp_bus_pkg::ST_IDLE:
			begin
				if (req_valid && !settings_bad)
				begin
					next_phase = exp_bus_pkg::ST_ADDR;
					next_count = exp_bus_pkg::phase_len(
						{2'h0, address_phase_setting});
				end
			end
			exp_bus_pkg::ST_ADDR:
			begin
				// Hold keeps us here; the released cycle itself still counts as one more clock.
				if (host_ready_hold || hold_seen)
				begin
					next_count = count;
				end
				else if (count_done)
				begin
					next_phase = exp_bus_pkg::ST_SETUP;
					next_count = exp_bus_pkg::phase_len(
						{2'h0, data_setup_phase_setting});
				end
			end
			exp_bus_pkg::ST_SETUP:
			begin
				if (hold_seen)
				begin
					next_count = count;
				end
				else if (count_done)
				begin
					next_phase = exp_bus_pkg::ST_STROBE;
					next_count = exp_bus_pkg::phase_len(
						{2'h0, data_strobe_phase_setting});
				end
			end
			exp_bus_pkg::ST_STROBE:
			begin
				if (host_ready_hold)
				begin
					next_count = count;
				end
				else if (use_wait && !wait_request_n)
				begin
					next_count = count;
				end
				else if (count_done || (wait_seen && wait_request_n && count != '0))
				begin
					next_phase = exp_bus_pkg::ST_HOLD;
					next_count = exp_bus_pkg::RECOV_BASE;
				end
			end
			exp_bus_pkg::ST_HOLD:
			begin
				if (count_done)
				begin
					next_phase = exp_bus_pkg::ST_RECOV;
					next_count = recovery_phase_setting;
				end
			end
			exp_bus_pkg::ST_RECOV:
			begin
				if (count_done)
				begin
					next_phase = exp_bus_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// Phase register and cycle counter.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			phase <= exp_bus_pkg::ST_IDLE;
			count <= '0;
		end
		else
		begin
			phase <= next_phase;
			count <= next_count;
		end
	end

	// A hold seen in address or setup phase forces one extra clock of the held phase after release.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			hold_seen <= 1'b0;
		end
		else if ((phase == exp_bus_pkg::ST_ADDR || phase == exp_bus_pkg::ST_SETUP) &&
			host_ready_hold)
		begin
			hold_seen <= 1'b1;
		end
		else
		begin
			hold_seen <= 1'b0;
		end
	end

	// A wait seen in this strobe phase arms the early end on its release.
	// Without it a peripheral that never waits would get a cut strobe.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wait_seen <= 1'b0;
		end
		else if (phase != exp_bus_pkg::ST_STROBE)
		begin
			wait_seen <= 1'b0;
		end
		else if (use_wait && !wait_request_n)
		begin
			wait_seen <= 1'b1;
		end
	end

	// Access attributes are latched when the access is taken.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			is_write <= 1'b0;
			use_wait <= 1'b0;
		end
		else if (phase == exp_bus_pkg::ST_IDLE && next_phase == exp_bus_pkg::ST_ADDR)
		begin
			is_write <= req_write;
			// The shared wait line only applies to the two strobe styles, not to sync writes in the read/write strobe style.
			use_wait <= (bus_style != exp_bus_pkg::STYLE_HOST_PORT) &&
				!(bus_style == exp_bus_pkg::STYLE_RW_STROBE && sync_write && req_write);
		end
	end

	// Bus pins: address and select together, strobe only in strobe phase.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			chip_select_n <= 8'hff;
			bus_addr <= '0;
			host_data_strobe_n <= 1'b1;
			bus_data_out <= '0;
			bus_data_oe <= 1'b0;
		end
		else
		begin
			if (phase == exp_bus_pkg::ST_IDLE && next_phase == exp_bus_pkg::ST_ADDR)
			begin
				chip_select_n <= ~(8'h01 << req_cs);
				bus_addr <= req_addr;
				bus_data_out <= req_wdata;
				bus_data_oe <= req_write;
			end
			else if (next_phase == exp_bus_pkg::ST_RECOV || next_phase == exp_bus_pkg::ST_IDLE)
			begin
				chip_select_n <= 8'hff;
			end
			// Write data stays driven through recovery to lengthen its hold after the strobe.
			if (next_phase == exp_bus_pkg::ST_IDLE)
			begin
				bus_data_oe <= 1'b0;
			end
			host_data_strobe_n <= (next_phase != exp_bus_pkg::ST_STROBE);
		end
	end

	// Read capture at the end of strobe phase, and the request handshake.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			req_ready <= 1'b0;
			setting_error <= 1'b0;
		end
		else
		begin
			rsp_valid <= (phase == exp_bus_pkg::ST_STROBE) && (next_phase == exp_bus_pkg::ST_HOLD);
			if (phase == exp_bus_pkg::ST_STROBE && next_phase == exp_bus_pkg::ST_HOLD && !is_write)
			begin
				rsp_rdata <= bus_data_in;
			end
			req_ready <= (phase == exp_bus_pkg::ST_IDLE) && req_valid && !settings_bad;
			setting_error <= settings_bad;
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	a_hold_keeps_addr: assert property (@(posedge clk) disable iff (sys_rst)
		(phase == exp_bus_pkg::ST_ADDR && host_ready_hold) |=> phase == exp_bus_pkg::ST_ADDR)
		else $error("left address phase while hold active");
	a_hold_keeps_strobe: assert property (@(posedge clk) disable iff (sys_rst)
		(phase == exp_bus_pkg::ST_STROBE && host_ready_hold) |=> phase == exp_bus_pkg::ST_STROBE)
		else $error("left strobe phase while hold active");
	a_release_extra_clock: assert property (@(posedge clk) disable iff (sys_rst)
		(phase == exp_bus_pkg::ST_ADDR && $past(host_ready_hold) && !host_ready_hold)
		|=> phase == exp_bus_pkg::ST_ADDR)
		else $error("no extra clock after hold release");
	a_wait_stretches: assert property (@(posedge clk) disable iff (sys_rst)
		(phase == exp_bus_pkg::ST_STROBE && use_wait && !wait_request_n)
		|=> phase == exp_bus_pkg::ST_STROBE)
		else $error("strobe ended while wait asserted");
	a_strobe_in_phase: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(host_data_strobe_n) |-> phase == exp_bus_pkg::ST_STROBE)
		else $error("strobe active outside strobe phase");
	a_cs_before_strobe: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(host_data_strobe_n) |-> chip_select_n != 8'hff)
		else $error("strobe without chip select");
	a_recov_no_cs: assert property (@(posedge clk) disable iff (sys_rst)
		phase == exp_bus_pkg::ST_RECOV |-> ##1 (chip_select_n == 8'hff))
		else $error("select active during recovery");
	a_read_response: assert property (@(posedge clk) disable iff (sys_rst)
		(phase == exp_bus_pkg::ST_STROBE && next_phase == exp_bus_pkg::ST_HOLD) |=> rsp_valid)
		else $error("missing response after strobe");
	a_no_early_end: assert property (@(posedge clk) disable iff (sys_rst)
		(phase == exp_bus_pkg::ST_STROBE && !wait_seen && !count_done)
		|=> phase == exp_bus_pkg::ST_STROBE)
		else $error("strobe ended early without a wait");
	a_bad_setting_idle: assert property (@(posedge clk) disable iff (sys_rst)
		(phase == exp_bus_pkg::ST_IDLE && settings_bad) |=> phase == exp_bus_pkg::ST_IDLE)
		else $error("access taken with bad settings");
	c_host_read: cover property (@(posedge clk) phase == exp_bus_pkg::ST_STROBE && !is_write);
	c_host_write: cover property (@(posedge clk) phase == exp_bus_pkg::ST_STROBE && is_write);
	c_hold_addr: cover property (@(posedge clk) phase == exp_bus_pkg::ST_ADDR && host_ready_hold);
	c_wait_stretch: cover property (@(posedge clk) phase == exp_bus_pkg::ST_STROBE && !wait_request_n);

endmodule

// ===== bench/dsp_port_model.sv
// Behavioural model of the DSP host port or slow peripheral on the far side.
`timescale 1ns/1ps
module dsp_port_model (
	input wire logic clk,
	input wire logic [7:0] chip_select_n,
	input wire logic host_data_strobe_n,
	input wire logic [15:0] read_word,
	input wire logic [3:0] hold_len,
	input wire logic [3:0] wait_len,
	output logic host_ready_hold,
	output logic wait_request_n,
	output logic [15:0] bus_data_in
);
	logic sel_d = 1'b0;
	logic st_d = 1'b0;
	logic [3:0] hc = 4'h0;
	logic [3:0] wc = 4'h0;

	// ==========================================================
	// Hold and wait counters
	// ==========================================================
	// Hold starts one clock after a select opens; wait starts on the strobe's second cycle.
	always @(posedge clk)
	begin
		sel_d <= ~&chip_select_n;
		st_d <= ~host_data_strobe_n;
		if (~&chip_select_n && !sel_d)
		begin
			hc <= hold_len;
		end
		else if (hc != 4'h0)
		begin
			hc <= hc - 4'h1;
		end
		if (!host_data_strobe_n && !st_d)
		begin
			wc <= wait_len;
		end
		else if (wc != 4'h0)
		begin
			wc <= wc - 4'h1;
		end
	end

	// The wait line rests high between accesses, as a pull-up would leave it.
	assign host_ready_hold = hc != 4'h0;
	assign wait_request_n = wc == 4'h0;
	// Outside the strobe the data is inverted, so a mistimed capture is caught.
	assign bus_data_in = host_data_strobe_n ? ~read_word : read_word;
endmodule

// ===== bench/tb.sv
// Self-checking testbench for the expansion bus access sequencer.
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic sync_write = 1'b0;
	logic [2:0] req_cs = 3'h0;
	logic [23:0] req_addr = 24'h0;
	logic [15:0] req_wdata = 16'h0;
	logic [15:0] read_word = 16'h0;
	exp_bus_pkg::bus_style_e bus_style = exp_bus_pkg::STYLE_HOST_PORT;
	logic [1:0] a_set = 2'h2;
	logic [1:0] s_set = 2'h2;
	logic [1:0] t_set = 2'h3;
	logic [3:0] r_set = 4'h1;
	logic [3:0] hold_len = 4'h0;
	logic [3:0] wait_len = 4'h0;
	logic host_ready_hold, wait_request_n, req_ready, rsp_valid, setting_error;
	logic host_data_strobe_n, bus_data_oe;
	logic [15:0] bus_data_in, rsp_rdata, bus_data_out, wd_rise, rd;
	logic [7:0] chip_select_n;
	logic [23:0] bus_addr;
	logic oe_rise, addr_ok, got_rsp, seen;
	logic cs_idle_d = 1'b1;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	int rel_cyc = 0;
	int gap = 0;
	int d_cs, d_st, d_end;

	exp_bus_seq exp_bus_seq_inst (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
		.req_write(req_write), .req_cs(req_cs), .req_addr(req_addr), .req_wdata(req_wdata),
		.bus_style(bus_style), .sync_write(sync_write), .address_phase_setting(a_set),
		.data_setup_phase_setting(s_set), .data_strobe_phase_setting(t_set),
		.recovery_phase_setting(r_set), .host_ready_hold(host_ready_hold),
		.wait_request_n(wait_request_n), .bus_data_in(bus_data_in), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .setting_error(setting_error),
		.chip_select_n(chip_select_n), .bus_addr(bus_addr),
		.host_data_strobe_n(host_data_strobe_n), .bus_data_out(bus_data_out),
		.bus_data_oe(bus_data_oe));
	dsp_port_model dsp_port_model_inst (.clk(clk), .chip_select_n(chip_select_n),
		.host_data_strobe_n(host_data_strobe_n), .read_word(read_word), .hold_len(hold_len),
		.wait_len(wait_len), .host_ready_hold(host_ready_hold),
		.wait_request_n(wait_request_n), .bus_data_in(bus_data_in));

	always #25 clk = ~clk;

	// Measure the idle gap between one select closing and the next opening.
	always @(negedge clk)
	begin
		cyc++;
		if (&chip_select_n && !cs_idle_d) rel_cyc = cyc;
		if (!(&chip_select_n) && cs_idle_d) gap = cyc - rel_cyc;
		cs_idle_d = &chip_select_n;
	end

	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic complete_run();
		$display("counts: comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One access; the request is held until the ready pulse has been seen.
	task automatic access(input logic wr, input logic [23:0] ad, input logic [15:0] wd);
		int i;
		d_cs = -1;
		d_st = -1;
		d_end = -1;
		addr_ok = 1'b1;
		got_rsp = 1'b0;
		@(negedge clk);
		req_valid = 1'b1;
		req_write = wr;
		req_addr = ad;
		req_wdata = wd;
		for (i = 0; i < 200 && !(got_rsp && d_end >= 0); i++)
		begin
			@(negedge clk);
			if (req_ready === 1'b1) req_valid = 1'b0;
			if (d_cs < 0 && chip_select_n !== 8'hff) d_cs = i;
			if (chip_select_n !== 8'hff && bus_addr !== ad) addr_ok = 1'b0;
			if (d_st < 0 && host_data_strobe_n === 1'b0) d_st = i;
			if (host_data_strobe_n === 1'b0) {wd_rise, oe_rise} = {bus_data_out, bus_data_oe};
			if (d_st >= 0 && d_end < 0 && host_data_strobe_n === 1'b1) d_end = i;
			if (rsp_valid === 1'b1) {got_rsp, rd} = {1'b1, rsp_rdata};
		end
		if (i >= 200)
		begin
			n_mismatch++;
			complete_run();
		end
	endtask

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial
	begin
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		access(1'b1, 24'h123456, 16'ha5c3);
		check(d_st - d_cs, 6);
		check(d_end - d_st, 4);
		check({oe_rise, wd_rise}, {1'b1, 16'ha5c3});
		check(addr_ok, 1);
		$display("test write done");
		read_word = 16'h5a3c;
		access(1'b0, 24'h000abc, 16'h0);
		check(rd, 16'h5a3c);
		check(gap >= 2, 1);
		$display("test read done");
		{hold_len, r_set} = {4'h4, 4'h6};
		access(1'b1, 24'h00f00d, 16'h0ff0);
		check(d_st - d_cs > 6, 1);
		check(gap >= 7, 1);
		$display("test hold done");
		{hold_len, wait_len, req_cs, r_set} = {4'h0, 4'h6, 3'h7, 4'h1};
		bus_style = exp_bus_pkg::STYLE_SEP_STROBE;
		access(1'b0, 24'h000100, 16'h0);
		check(d_end - d_st > 4, 1);
		wait_len = 4'h1;
		access(1'b0, 24'h000102, 16'h0);
		check(d_end - d_st < 4, 1);
		wait_len = 4'h0;
		access(1'b0, 24'h000104, 16'h0);
		check(d_end - d_st, 4);
		$display("test wait done");
		bus_style = exp_bus_pkg::STYLE_RW_STROBE;
		{sync_write, wait_len} = {1'b1, 4'h6};
		access(1'b1, 24'h000200, 16'h1234);
		check(d_end - d_st, 4);
		$display("test sync write done");
		bus_style = exp_bus_pkg::STYLE_HOST_PORT;
		{wait_len, a_set, seen} = {4'h0, 2'h1, 1'b0};
		req_valid = 1'b1;
		repeat (12)
		begin
			@(negedge clk);
			if (req_ready !== 1'b0) seen = 1'b1;
		end
		check({setting_error, seen}, 2'h2);
		req_valid = 1'b0;
		$display("test refusal done");
		complete_run();
	end
endmodule
